// ### verilog/atacmd_pkg.sv
// Package: constants and types of the command engine
package atacmd_pkg;

	// ----------------------------------------
	// Command opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_SMART       = 8'hb0;
	localparam logic [7:0] OP_STANDBY     = 8'he2;
	localparam logic [7:0] OP_STANDBY_IMM = 8'he0;
	localparam logic [7:0] OP_WR_BUF      = 8'he8;
	localparam logic [7:0] OP_WR_DMA      = 8'hca;
	localparam logic [7:0] OP_WR_DMA_EXT  = 8'h35;
	localparam logic [7:0] OP_WR_DMA_FUA  = 8'h3d;
	localparam logic [7:0] OP_WR_LOG      = 8'h3f;
	localparam logic [7:0] OP_WR_MULT     = 8'hc5;
	localparam logic [7:0] OP_WR_MULT_EXT = 8'h39;
	localparam logic [7:0] OP_WR_MULT_FUA = 8'hce;
	localparam logic [7:0] OP_WR_SEC      = 8'h30;
	localparam logic [7:0] OP_WR_SEC_NR   = 8'h31;
	localparam logic [7:0] OP_WR_SEC_EXT  = 8'h34;

	// ----------------------------------------
	// SMART subcommands and codes
	// ----------------------------------------
	localparam logic [7:0] SUB_AUTOSAVE = 8'hd2;
	localparam logic [7:0] SUB_SAVE     = 8'hd3;
	localparam logic [7:0] SUB_ENABLE   = 8'hd8;
	localparam logic [7:0] SUB_DISABLE  = 8'hd9;
	localparam logic [7:0] SUB_STATUS   = 8'hda;
	localparam logic [7:0] AUTOSAVE_ON  = 8'hf1;
	localparam logic [7:0] OK_LOW       = 8'h4f;
	localparam logic [7:0] OK_HIGH      = 8'hc2;
	localparam logic [7:0] BAD_LOW      = 8'hf4;
	localparam logic [7:0] BAD_HIGH     = 8'h2c;

	// ----------------------------------------
	// Transfer geometry
	// ----------------------------------------
	localparam int         WORDS_PER_SEC = 128;
	localparam logic [6:0] LAST_WORD     = 7'h7f;
	localparam logic [16:0] SEC28_MAX    = 17'h00100;
	localparam logic [16:0] SEC48_MAX    = 17'h10000;
	localparam int         W59_VALID_BIT = 8;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_FEAT    = 8'h04;
	localparam logic [7:0] REG_COUNT   = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0c;
	localparam logic [7:0] REG_CYL     = 8'h10;
	localparam logic [7:0] REG_DATA    = 8'h14;
	localparam logic [7:0] REG_MULT    = 8'h18;
	localparam logic [7:0] REG_CONFIG  = 8'h1c;
	localparam logic [7:0] REG_PERSIST = 8'h20;
	localparam logic [7:0] REG_BUF     = 8'h24;

	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int ST_BSY   = 0;
	localparam int ST_DRQ   = 1;
	localparam int ST_ERR   = 2;
	localparam int ST_ABRT  = 3;
	localparam int ST_DONE  = 4;
	localparam int ST_STBY  = 5;
	localparam int ST_TMR   = 6;
	localparam int ST_FLUSH = 7;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Non-volatile settings carried as one word
	typedef struct packed {
		logic       smart_on;
		logic       autosave_on;
		logic [7:0] autosave_code;
	} atacmd_persist_t;

	// Command request as presented by the host
	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  feature;
		logic [15:0] count;
	} atacmd_req_t;

endpackage

// ### verilog/atacmd_engine.sv
// Command engine: SMART, standby and write commands
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
module atacmd_engine
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Non-volatile settings store
	input  wire logic [9:0]  nv_load,
	output logic [9:0]       nv_store,
	// Media side
	input  wire logic        defect_pred,
	input  wire logic        media_err,
	input  wire logic        flush_ack,
	output logic             flush_req,
	// Host notification
	output logic             cmd_irq
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_DECODE, S_XFER, S_BLKEND,
		S_FLUSH, S_DONE} atacmd_state_t;

	atacmd_state_t          state_r;
	atacmd_pkg::atacmd_req_t req_r;
	atacmd_pkg::atacmd_persist_t pers_r;
	logic [7:0]  status_r;
	logic [15:0] cyl_r;
	logic [8:0]  w59_r;
	logic [7:0]  mult_r;
	logic        mult_set_r;
	logic        dma_mode_r;
	logic        attr_dirty_r;
	logic [7:0]  stby_timer_r;
	logic [16:0] secs_left_r;
	logic [7:0]  blk_left_r;
	logic [6:0]  word_r;
	logic        multi_r;
	logic        fua_r;
	logic        is_buf_r;
	logic [6:0]  buf_ptr_r;
	logic [31:0] buf_mem [atacmd_pkg::WORDS_PER_SEC];
	logic        aw_ok_r;
	logic        w_ok_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic        go_r;
	logic        aw_hs;
	logic        w_hs;
	logic        wr_do;
	logic        ar_hs;
	logic        data_wr;
	logic [16:0] count_sec;
	logic [7:0]  blk_size;
	logic        loaded_r;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs  = s_axi_wvalid && s_axi_wready;
	assign wr_do = aw_ok_r && w_ok_r;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign data_wr = wr_do && (awaddr_r == atacmd_pkg::REG_DATA)
		&& status_r[atacmd_pkg::ST_DRQ];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_ok_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_ok_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (wr_do)
			begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r > atacmd_pkg::REG_BUF)
					? atacmd_pkg::RESP_SLVERR : atacmd_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else if (ar_hs)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= atacmd_pkg::RESP_OKAY;
			case (s_axi_araddr)
				atacmd_pkg::REG_CMD:     s_axi_rdata <= {24'h000000, req_r.opcode};
				atacmd_pkg::REG_FEAT:    s_axi_rdata <= {24'h000000, req_r.feature};
				atacmd_pkg::REG_COUNT:   s_axi_rdata <= {16'h0000, req_r.count};
				atacmd_pkg::REG_STATUS:  s_axi_rdata <= {16'h0000, stby_timer_r,
					status_r};
				atacmd_pkg::REG_CYL:     s_axi_rdata <= {16'h0000, cyl_r};
				atacmd_pkg::REG_MULT:    s_axi_rdata <= {15'h0000, mult_set_r,
					7'h00, w59_r};
				atacmd_pkg::REG_CONFIG:  s_axi_rdata <= {30'h00000000,
					attr_dirty_r, dma_mode_r};
				atacmd_pkg::REG_PERSIST: s_axi_rdata <= {22'h000000, pers_r};
				atacmd_pkg::REG_BUF:     s_axi_rdata <= buf_mem[buf_ptr_r];
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= atacmd_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Host-written task file and configuration
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_r <= '0;
			go_r <= 1'b0;
			w59_r <= 9'h000;
			dma_mode_r <= 1'b0;
		end
		else
		begin
			go_r <= 1'b0;
			if (wr_do && state_r == S_IDLE)
			begin
				case (awaddr_r)
					atacmd_pkg::REG_CMD:
					begin
						req_r.opcode <= wdata_r[7:0];
						go_r <= 1'b1;
					end
					atacmd_pkg::REG_FEAT:   req_r.feature <= wdata_r[7:0];
					atacmd_pkg::REG_COUNT:  req_r.count <= wdata_r[15:0];
					atacmd_pkg::REG_MULT:   w59_r <= wdata_r[8:0];
					atacmd_pkg::REG_CONFIG: dma_mode_r <= wdata_r[0];
					default: ;
				endcase
			end
		end
	end

	// Block size: set value, else word 59
	assign mult_set_r = (mult_r != 8'h00);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mult_r <= 8'h00;
		else if (wr_do && state_r == S_IDLE && awaddr_r == atacmd_pkg::REG_MULT)
			mult_r <= wdata_r[23:16];
	end
	assign blk_size = mult_set_r ? mult_r : w59_r[7:0];

	// ----------------------------------------
	// Persistent SMART settings
	// ----------------------------------------
	assign nv_store = pers_r;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pers_r <= '0;
			loaded_r <= 1'b0;
		end
		else if (!loaded_r)
		begin
			pers_r <= nv_load;
			loaded_r <= 1'b1;
		end
		else if (state_r == S_DECODE && req_r.opcode == atacmd_pkg::OP_SMART)
		begin
			if (req_r.feature == atacmd_pkg::SUB_ENABLE)
				pers_r.smart_on <= 1'b1;
			else if (pers_r.smart_on)
			begin
				if (req_r.feature == atacmd_pkg::SUB_DISABLE)
				begin
					pers_r.smart_on <= 1'b0;
					pers_r.autosave_on <= 1'b0;
				end
				else if (req_r.feature == atacmd_pkg::SUB_AUTOSAVE)
				begin
					pers_r.autosave_code <= req_r.count[7:0];
					if (req_r.count[7:0] == 8'h00)
						pers_r.autosave_on <= 1'b0;
					else if (req_r.count[7:0] == atacmd_pkg::AUTOSAVE_ON)
						pers_r.autosave_on <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	assign count_sec = (req_r.count[7:0] == 8'h00 && req_r.opcode != atacmd_pkg::OP_WR_SEC_EXT
		&& req_r.opcode != atacmd_pkg::OP_WR_DMA_EXT
		&& req_r.opcode != atacmd_pkg::OP_WR_DMA_FUA
		&& req_r.opcode != atacmd_pkg::OP_WR_MULT_EXT
		&& req_r.opcode != atacmd_pkg::OP_WR_MULT_FUA
		&& req_r.opcode != atacmd_pkg::OP_WR_LOG)
		? atacmd_pkg::SEC28_MAX
		: (req_r.count == 16'h0000) ? atacmd_pkg::SEC48_MAX
		: {1'b0, (req_r.opcode == atacmd_pkg::OP_WR_SEC
			|| req_r.opcode == atacmd_pkg::OP_WR_SEC_NR
			|| req_r.opcode == atacmd_pkg::OP_WR_DMA
			|| req_r.opcode == atacmd_pkg::OP_WR_MULT)
			? {8'h00, req_r.count[7:0]} : req_r.count};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= S_IDLE;
			status_r <= 8'h00;
			cyl_r <= 16'h0000;
			secs_left_r <= 17'h00000;
			blk_left_r <= 8'h00;
			word_r <= 7'h00;
			multi_r <= 1'b0;
			fua_r <= 1'b0;
			is_buf_r <= 1'b0;
			stby_timer_r <= 8'h00;
			attr_dirty_r <= 1'b0;
			flush_req <= 1'b0;
			cmd_irq <= 1'b0;
		end
		else
		begin
			cmd_irq <= 1'b0;
			if (data_wr)
				attr_dirty_r <= 1'b1;
			case (state_r)
				S_IDLE:
				if (go_r)
				begin
					state_r <= S_DECODE;
					status_r <= 8'h01; // Busy, all else clear
				end
				S_DECODE:
				begin
					state_r <= S_DONE;
					multi_r <= 1'b0;
					fua_r <= 1'b0;
					is_buf_r <= 1'b0;
					word_r <= 7'h00;
					case (req_r.opcode)
						atacmd_pkg::OP_SMART:
						if (!pers_r.smart_on && req_r.feature != atacmd_pkg::SUB_ENABLE)
							status_r[atacmd_pkg::ST_ABRT] <= 1'b1;
						else
							case (req_r.feature)
								atacmd_pkg::SUB_AUTOSAVE, atacmd_pkg::SUB_ENABLE: ;
								atacmd_pkg::SUB_DISABLE:
									attr_dirty_r <= 1'b0;
								atacmd_pkg::SUB_SAVE:
								begin
									flush_req <= 1'b1;
									state_r <= S_FLUSH;
								end
								atacmd_pkg::SUB_STATUS:
									cyl_r <= defect_pred
										? {atacmd_pkg::BAD_HIGH, atacmd_pkg::BAD_LOW}
										: {atacmd_pkg::OK_HIGH, atacmd_pkg::OK_LOW};
								default:
									status_r[atacmd_pkg::ST_ABRT] <= 1'b1;
							endcase
						atacmd_pkg::OP_STANDBY:
						begin
							status_r[atacmd_pkg::ST_STBY] <= 1'b1;
							stby_timer_r <= req_r.count[7:0];
						end
						atacmd_pkg::OP_STANDBY_IMM:
							status_r[atacmd_pkg::ST_STBY] <= 1'b1;
						atacmd_pkg::OP_WR_BUF:
						begin
							is_buf_r <= 1'b1;
							secs_left_r <= 17'h00001;
							blk_left_r <= 8'h01;
							state_r <= S_XFER;
						end
						atacmd_pkg::OP_WR_MULT, atacmd_pkg::OP_WR_MULT_EXT,
						atacmd_pkg::OP_WR_MULT_FUA:
						if (!mult_set_r && (!w59_r[atacmd_pkg::W59_VALID_BIT]
							|| w59_r[7:0] == 8'h00))
							status_r[atacmd_pkg::ST_ABRT] <= 1'b1;
						else
						begin
							multi_r <= 1'b1;
							fua_r <= (req_r.opcode == atacmd_pkg::OP_WR_MULT_FUA);
							secs_left_r <= count_sec;
							blk_left_r <= (count_sec < {9'h000, blk_size})
								? count_sec[7:0] : blk_size;
							state_r <= S_XFER;
						end
						atacmd_pkg::OP_WR_DMA, atacmd_pkg::OP_WR_DMA_EXT,
						atacmd_pkg::OP_WR_DMA_FUA:
						if (!dma_mode_r)
							status_r[atacmd_pkg::ST_ABRT] <= 1'b1;
						else
						begin
							fua_r <= (req_r.opcode == atacmd_pkg::OP_WR_DMA_FUA);
							secs_left_r <= count_sec;
							blk_left_r <= 8'h01;
							state_r <= S_XFER;
						end
						atacmd_pkg::OP_WR_SEC, atacmd_pkg::OP_WR_SEC_NR,
						atacmd_pkg::OP_WR_SEC_EXT, atacmd_pkg::OP_WR_LOG:
						begin
							secs_left_r <= count_sec;
							blk_left_r <= 8'h01;
							state_r <= S_XFER;
						end
						default:
							status_r[atacmd_pkg::ST_ABRT] <= 1'b1;
					endcase
				end
				S_XFER:
				begin
					status_r[atacmd_pkg::ST_BSY] <= 1'b0;
					status_r[atacmd_pkg::ST_DRQ] <= 1'b1;
					if (data_wr)
					begin
						word_r <= word_r + 7'h01;
						if (media_err)
							status_r[atacmd_pkg::ST_ERR] <= 1'b1;
						if (word_r == atacmd_pkg::LAST_WORD)
						begin
							secs_left_r <= secs_left_r - 17'h00001;
							blk_left_r <= blk_left_r - 8'h01;
							if (blk_left_r == 8'h01 || secs_left_r == 17'h00001)
							begin
								status_r[atacmd_pkg::ST_DRQ] <= 1'b0;
								status_r[atacmd_pkg::ST_BSY] <= 1'b1;
								state_r <= S_BLKEND;
							end
						end
					end
				end
				S_BLKEND:
				if (status_r[atacmd_pkg::ST_ERR] || secs_left_r == 17'h00000)
				begin
					if (fua_r && !status_r[atacmd_pkg::ST_ERR])
					begin
						flush_req <= 1'b1;
						state_r <= S_FLUSH;
					end
					else
						state_r <= S_DONE;
				end
				else
				begin
					cmd_irq <= 1'b1;
					blk_left_r <= !multi_r ? 8'h01
						: (secs_left_r < {9'h000, blk_size})
						? secs_left_r[7:0] : blk_size;
					state_r <= S_XFER;
				end
				S_FLUSH:
				begin
					status_r[atacmd_pkg::ST_FLUSH] <= 1'b1;
					if (flush_ack)
					begin
						flush_req <= 1'b0;
						attr_dirty_r <= 1'b0;
						state_r <= S_DONE;
					end
				end
				S_DONE:
				begin
					status_r[atacmd_pkg::ST_BSY] <= 1'b0;
					status_r[atacmd_pkg::ST_DRQ] <= 1'b0;
					status_r[atacmd_pkg::ST_FLUSH] <= 1'b0;
					status_r[atacmd_pkg::ST_TMR] <= (stby_timer_r != 8'h00);
					status_r[atacmd_pkg::ST_DONE] <= 1'b1;
					cmd_irq <= 1'b1;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Sector buffer and shared read pointer
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (data_wr && is_buf_r)
			buf_mem[word_r] <= wdata_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			buf_ptr_r <= 7'h00;
		else if (state_r == S_DECODE && req_r.opcode == atacmd_pkg::OP_WR_BUF)
			buf_ptr_r <= 7'h00;
		else if (ar_hs && s_axi_araddr == atacmd_pkg::REG_BUF)
			buf_ptr_r <= buf_ptr_r + 7'h01;
	end

endmodule

// ### testbench/atacmd_engine_sva.sv
// Checker: properties of the command engine
module atacmd_engine_sva
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Other ports
	input wire logic [9:0]  nv_load,
	input wire logic [9:0]  nv_store,
	input wire logic        flush_req,
	input wire logic        flush_ack,
	input wire logic        cmd_irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_irq_pulse: assert property (cmd_irq |=> !cmd_irq)
		else $error("irq pulse too long");
	chk_flush_hold: assert property (flush_req && !flush_ack |=> flush_req)
		else $error("flush request dropped");
	chk_commit_first: assert property (flush_req |-> !cmd_irq)
		else $error("irq before commit");
	chk_nv_restore: assert property ($rose(rst_n) |-> ##[1:2] nv_store == nv_load)
		else $error("settings not restored");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid dropped");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rvalid dropped");
	chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during bvalid");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during rvalid");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule

bind atacmd_engine atacmd_engine_sva chk
(
	.sys_clk       (sys_clk),
	.rst_n         (rst_n),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.nv_load       (nv_load),
	.nv_store      (nv_store),
	.flush_req     (flush_req),
	.flush_ack     (flush_ack),
	.cmd_irq       (cmd_irq)
);

// ### testbench/atacmd_media_model.sv
// Partner: settings store and media commit beside the command engine
module atacmd_media_model
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Settings store
	input  wire logic [9:0] nv_store,
	output logic      [9:0] nv_load,
	// Media commit
	input  wire logic       flush_req,
	input  wire logic       slow,
	output logic            flush_ack
);
	// ----------------------------------------
	// Store survives resets
	// ----------------------------------------
	logic [1:0] boot_r;
	logic [3:0] wait_r;

	initial nv_load = 10'h000;
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			boot_r <= 2'h0;
		else if (boot_r != 2'h3)
			boot_r <= boot_r + 2'h1;
	always @(posedge sys_clk)
		if (rst_n && boot_r == 2'h3)
			nv_load <= nv_store;

	// ----------------------------------------
	// Commit acknowledge
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_n)
		if (!rst_n || !flush_req)
			wait_r <= 4'h0;
		else if (wait_r != 4'hf)
			wait_r <= wait_r + 4'h1;
	assign flush_ack = flush_req && wait_r >= (slow ? 4'h6 : 4'h1);
endmodule

// ### testbench/atacmd_engine_bench.sv
// Testbench: drives the command engine over its register bus
module atacmd_engine_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int          W      = atacmd_pkg::WORDS_PER_SEC;
	localparam logic [31:0] M_DRQ  = 32'h00000002;
	localparam logic [31:0] M_IDLE = 32'h00000083;
	logic        sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, cmd_irq, slow;
	logic        defect_pred, media_err, flush_ack, flush_req;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, p;
	logic [1:0]  bresp, rresp, rsp;
	logic [9:0]  nv_load, nv_store;
	int          bad_count, check_count, irq_cnt, k;

	atacmd_engine DUT
	(
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hf),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.nv_load       (nv_load),
		.nv_store      (nv_store),
		.defect_pred   (defect_pred),
		.media_err     (media_err),
		.flush_ack     (flush_ack),
		.flush_req     (flush_req),
		.cmd_irq       (cmd_irq)
	);
	atacmd_media_model media
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.nv_store  (nv_store),
		.nv_load   (nv_load),
		.flush_req (flush_req),
		.slow      (slow),
		.flush_ack (flush_ack)
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		if (cmd_irq === 1'b1)
			irq_cnt++;

	function automatic logic [31:0] pat(input int n);
		return {16'(n) ^ 16'h5a3c, 16'(n)};
	endfunction

	task automatic check(input string what, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw, tb;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge sys_clk);
			ta = awready === 1'b1;
			tw = wready === 1'b1;
			tb = bvalid === 1'b1;
			@(posedge sys_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge sys_clk); while (arready !== 1'b1);
		@(posedge sys_clk);
		arvalid <= 1'b0;
		do @(negedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
		@(posedge sys_clk);
		rready <= 1'b0;
	endtask

	task automatic poll(input logic [31:0] m, v, output logic [31:0] st);
		int n;
		n = 0;
		do
		begin
			axi_rd(atacmd_pkg::REG_STATUS, st);
			n++;
		end
		while ((st & m) !== v && n < 400);
		check("status wait", st & m, v);
	endtask

	task automatic run_cmd(input logic [7:0] op, f, input logic [15:0] c,
		input int ns, input logic ab, input int ni);
		logic [31:0] st;
		int s;
		axi_wr(atacmd_pkg::REG_FEAT, {24'h0, f});
		axi_wr(atacmd_pkg::REG_COUNT, {16'h0, c});
		s = irq_cnt;
		k = 0;
		axi_wr(atacmd_pkg::REG_CMD, {24'h0, op});
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < ns * W; i++)
		begin
			if (i % W == 0)
				poll(M_DRQ, M_DRQ, st);
			axi_wr(atacmd_pkg::REG_DATA, pat(k));
			k++;
		end
		poll(M_IDLE, 32'h0, st);
		repeat (3) @(posedge sys_clk);
		check("abort", {31'h0, st[atacmd_pkg::ST_ABRT]}, {31'h0, ab});
		check("irq count", 32'(irq_cnt - s), 32'(ni));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_smart;
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_ENABLE, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_PERSIST, p);
		check("smart on", {31'h0, p[9]}, 32'h1);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_ENABLE, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_PERSIST, rd);
		check("enable again", rd, p);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_AUTOSAVE,
			{8'h0, atacmd_pkg::AUTOSAVE_ON}, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_PERSIST, rd);
		check("autosave on", {31'h0, rd[8]}, 32'h1);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_AUTOSAVE, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_PERSIST, rd);
		check("autosave off", {31'h0, rd[8]}, 32'h0);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_AUTOSAVE, 16'h0055, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_PERSIST, p);
		check("vendor code", {24'h0, p[7:0]}, 32'h55);
		slow <= 1'b1;
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_SAVE, 0, 0, 0, 1);
		slow <= 1'b0;
		rst_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		axi_rd(atacmd_pkg::REG_PERSIST, rd);
		check("settings kept", rd, p);
		$display("test smart done");
	endtask

	task automatic t_status;
		defect_pred <= 1'b0;
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_STATUS, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_CYL, rd);
		check("healthy", {16'h0, rd[15:0]},
			{16'h0, atacmd_pkg::OK_HIGH, atacmd_pkg::OK_LOW});
		defect_pred <= 1'b1;
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_STATUS, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_CYL, rd);
		check("defect", {16'h0, rd[15:0]},
			{16'h0, atacmd_pkg::BAD_HIGH, atacmd_pkg::BAD_LOW});
		defect_pred <= 1'b0;
		run_cmd(atacmd_pkg::OP_SMART, 8'h77, 0, 0, 1, 1);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_DISABLE, 0, 0, 0, 1);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_STATUS, 0, 0, 1, 1);
		run_cmd(atacmd_pkg::OP_SMART, atacmd_pkg::SUB_ENABLE, 0, 0, 0, 1);
		run_cmd(8'h7b, 8'h00, 0, 0, 1, 1);
		axi_rd(8'h40, rd);
		check("unmapped resp", {30'h0, rsp}, {30'h0, atacmd_pkg::RESP_SLVERR});
		$display("test status done");
	endtask

	task automatic t_standby;
		run_cmd(atacmd_pkg::OP_STANDBY, 8'h00, 16'h0005, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_STATUS, rd);
		check("timer on", {21'h0, rd[15:5]}, {21'h0, 8'h05, 3'b011});
		run_cmd(atacmd_pkg::OP_STANDBY, 8'h00, 16'h0000, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_STATUS, rd);
		check("timer off", {30'h0, rd[6:5]}, 32'h1);
		run_cmd(atacmd_pkg::OP_STANDBY_IMM, 8'h00, 0, 0, 0, 1);
		axi_rd(atacmd_pkg::REG_STATUS, rd);
		check("standby now", {31'h0, rd[5]}, 32'h1);
		$display("test standby done");
	endtask

	task automatic t_writes;
		run_cmd(atacmd_pkg::OP_WR_BUF, 8'h00, 16'h0001, 1, 0, 1);
		for (int i = 0; i < W; i++)
		begin
			axi_rd(atacmd_pkg::REG_BUF, rd);
			check("buffer word", rd, pat(i));
		end
		run_cmd(atacmd_pkg::OP_WR_SEC, 8'h00, 16'h0002, 2, 0, 2);
		run_cmd(atacmd_pkg::OP_WR_SEC_NR, 8'h00, 16'h0001, 1, 0, 1);
		run_cmd(atacmd_pkg::OP_WR_SEC_EXT, 8'h00, 16'h0003, 3, 0, 3);
		run_cmd(atacmd_pkg::OP_WR_LOG, 8'h00, 16'h0001, 1, 0, 1);
		run_cmd(atacmd_pkg::OP_WR_DMA, 8'h00, 16'h0001, 0, 1, 1);
		axi_wr(atacmd_pkg::REG_CONFIG, 32'h1);
		run_cmd(atacmd_pkg::OP_WR_DMA, 8'h00, 16'h0001, 1, 0, 1);
		run_cmd(atacmd_pkg::OP_WR_DMA_EXT, 8'h00, 16'h0001, 1, 0, 1);
		slow <= 1'b1;
		run_cmd(atacmd_pkg::OP_WR_DMA_FUA, 8'h00, 16'h0001, 1, 0, 1);
		$display("test writes done");
	endtask

	task automatic t_multi;
		slow <= 1'b0;
		run_cmd(atacmd_pkg::OP_WR_MULT, 8'h00, 16'h0003, 0, 1, 1);
		axi_wr(atacmd_pkg::REG_MULT, 32'h00020102);
		run_cmd(atacmd_pkg::OP_WR_MULT, 8'h00, 16'h0003, 3, 0, 2);
		run_cmd(atacmd_pkg::OP_WR_MULT_EXT, 8'h00, 16'h0004, 4, 0, 2);
		slow <= 1'b1;
		run_cmd(atacmd_pkg::OP_WR_MULT_FUA, 8'h00, 16'h0002, 2, 0, 1);
		media_err <= 1'b1;
		run_cmd(atacmd_pkg::OP_WR_MULT, 8'h00, 16'h0004, 2, 0, 1);
		media_err <= 1'b0;
		axi_rd(atacmd_pkg::REG_STATUS, rd);
		check("write error", {31'h0, rd[atacmd_pkg::ST_ERR]}, 32'h1);
		$display("test multiple done");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		$display("[ERR] watchdog expected finish seen hang");
		finish_test;
	end

	initial
	begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{slow, defect_pred, media_err, awaddr, araddr, wdata} = '0;
		{bad_count, check_count, irq_cnt, k} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_smart;
		t_status;
		t_standby;
		t_writes;
		t_multi;
		finish_test;
	end
endmodule
